// ===== rtl/ddp_cmd_slot.sv
// one procedure-command trigger: 3 fires once, 0 re-arms
// assumes wrEn is a one-cycle strobe from the parameter decoder
`default_nettype none
module ddp_cmd_slot
    import ddp_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset, // async reset, high
    input wire logic wrEn, // write strobe for this command
    input wire logic [1:0] wrVal, // low bits of written value
    input wire logic allowed, // command usable now
    output logic fire, // one-cycle execute pulse
    output logic refused, // write of 3 while not allowed
    output logic [1:0] value // last accepted value
);
    logic armed_r;
    logic [1:0] value_r;
    logic fire_r;

    assign refused = wrEn && wrVal == CMD_EXEC && !allowed;
    assign fire = fire_r;
    assign value = value_r;

    // last accepted value, held for read-back
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            value_r <= CMD_IDLE;
        end else if (wrEn && !refused) begin
            value_r <= wrVal;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            armed_r <= 1'b1;
            fire_r <= 1'b0;
        end else begin
            fire_r <= 1'b0;
            if (wrEn && wrVal == CMD_EXEC && allowed && armed_r) begin
                fire_r <= 1'b1;
                armed_r <= 1'b0;
            end else if (wrEn && wrVal == CMD_IDLE) begin
                armed_r <= 1'b1;
            end
        end
    end
endmodule : ddp_cmd_slot
`default_nettype wire

// ===== rtl/ddp_drive.sv
// drive end: warning, status-flag and diagnostic parameters, procedure commands
// assumes motion inputs and strap macAddr are synchronous to clk
//
// Chosen here: the address map and the plain strobed port.
`default_nettype none
module ddp_drive
    import ddp_pkg::*;
#(
    parameter bit STEPPER_VARIANT = 1'b1,
    parameter int MOT_W = 16,
    parameter int POS_W = 32
) (
    input wire logic clk, // system clock
    input wire logic reset, // async reset, high
    ddp_if.drive link, // parameter link
    input wire logic undervoltageWarning, // power section low
    input wire logic posLimitHit, // beyond positive limit
    input wire logic negLimitHit, // beyond negative limit
    input wire logic [MOT_W-1:0] torqueActual, // torque magnitude
    input wire logic [MOT_W-1:0] speedActual, // speed magnitude
    input wire logic [POS_W-1:0] posActual, // actual position
    input wire logic [POS_W-1:0] posCommand, // commanded position
    input wire logic errorEvent, // class 1 error pulse
    input wire logic driveProfile, // drive profile selected
    input wire logic [47:0] macAddr, // hardware address strap
    output logic [NCMD-1:0] cmdFire, // execute pulses
    output logic errLatched, // class 1 error pending
    output logic [31:0] ipAddr // current IP address
);
    if (MOT_W < 1 || MOT_W > 16 || POS_W < 2 || POS_W > 32) begin : g_chk
        $error("ddp_drive: MOT_W must be 1..16 and POS_W 2..32");
    end

    function automatic logic [NCMD-1:0] cmdMatch(input logic [ID_W-1:0] id);
        logic [NCMD-1:0] m;
        m = '0;
        for (int i = 0; i < NCMD; i++) begin
            m[i] = (id == CMD_IDS[i]);
        end
        return m;
    endfunction : cmdMatch

    function automatic logic [POS_W-1:0] absDiff(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
        return (a >= b) ? a - b : b - a;
    endfunction : absDiff

    logic [15:0] stdWarn, vendWarn, statFlag, statusWord;
    logic [31:0] diagNum, diagMsg;
    logic [NCMD-1:0] cmdSupported, cmdHit, cmdRefused;
    logic [1:0] cmdValue [NCMD];
    logic [MOT_W-1:0] torqLim_r, speedLim_r;
    logic [POS_W-1:0] posWin_r;
    logic [31:0] ip_r, subnet_r, gateway_r;
    logic ipLoaded_r, errLatched_r, ack_r, err_r;
    logic [31:0] rdata_r;
    logic wrStb, rdStb;
    logic [31:0] rdMux;
    logic rdOk, wrOk;

    assign wrStb = link.parReq && link.parWr;
    assign rdStb = link.parReq && !link.parWr;
    assign cmdHit = cmdMatch(link.parId);
    assign cmdSupported = driveProfile ? {NCMD{1'b1}} : ~CMD_PROFILE_MASK;

    // warning and flag words from live conditions; the status word also carries the latched class 1 error
    always_comb begin
        stdWarn = '0;
        vendWarn = '0;
        statFlag = '0;
        stdWarn[STD_UV_BIT] = undervoltageWarning;
        if (STEPPER_VARIANT) begin
            vendWarn[VEND_POS_BIT] = posLimitHit;
            vendWarn[VEND_NEG_BIT] = negLimitHit;
        end
        stdWarn[STD_VEND_BIT] = |vendWarn;
        statFlag[FLAG_TORQ_BIT] = torqueActual >= torqLim_r;
        statFlag[FLAG_SPEED_BIT] = speedActual >= speedLim_r;
        statFlag[FLAG_INPOS_BIT] = absDiff(posActual, posCommand) <= posWin_r;
        statusWord = '0;
        statusWord[STAT_WARN_BIT] = |stdWarn;
        statusWord[STAT_ERR_BIT] = errLatched_r;
    end

    // highest-priority active warning names itself
    always_comb begin
        if (undervoltageWarning) begin
            diagNum = DIAG_UV;
            diagMsg = MSG_UV;
        end else if (vendWarn[VEND_POS_BIT]) begin
            diagNum = DIAG_POS;
            diagMsg = MSG_POS;
        end else if (vendWarn[VEND_NEG_BIT]) begin
            diagNum = DIAG_NEG;
            diagMsg = MSG_NEG;
        end else begin
            diagNum = DIAG_NONE;
            diagMsg = MSG_NONE;
        end
    end

    // command slots
    for (genvar i = 0; i < NCMD; i++) begin : g_cmd
        ddp_cmd_slot ddp_cmd_slot_inst (
            .clk(clk),
            .reset(reset),
            .wrEn(wrStb && cmdHit[i]),
            .wrVal(link.parWData[1:0]),
            .allowed(cmdSupported[i]),
            .fire(cmdFire[i]),
            .refused(cmdRefused[i]),
            .value(cmdValue[i])
        );
    end

    // class 1 latch, a new error beats a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            errLatched_r <= 1'b0;
        end else if (errorEvent) begin
            errLatched_r <= 1'b1;
        end else if (cmdFire[CMD_CLR_ERR]) begin
            errLatched_r <= 1'b0;
        end
    end

    // read decode
    always_comb begin
        rdMux = '0;
        rdOk = 1'b1;
        case (link.parId)
            PAR_STATUS: rdMux = {16'h0000, statusWord};
            PAR_STD_WARN: rdMux = {16'h0000, stdWarn};
            PAR_VEND_WARN: begin
                rdMux = {16'h0000, vendWarn};
                rdOk = STEPPER_VARIANT;
            end
            PAR_STAT_FLAG: rdMux = {16'h0000, statFlag};
            PAR_DIAG_NUM: rdMux = diagNum;
            PAR_DIAG_MSG: rdMux = diagMsg;
            PAR_CMD_LIST: rdMux = {{(32-NCMD){1'b0}}, cmdSupported};
            PAR_TORQ_LIM: rdMux = 32'(torqLim_r);
            PAR_SPEED_LIM: rdMux = 32'(speedLim_r);
            PAR_POS_WIN: rdMux = 32'(posWin_r);
            PAR_MAC: rdMux = macAddr[31:0];
            PAR_IP: rdMux = ip_r;
            PAR_SUBNET: rdMux = subnet_r;
            PAR_GATEWAY: rdMux = gateway_r;
            default: begin
                rdOk = 1'b0;
                for (int i = 0; i < NCMD; i++) begin
                    if (cmdHit[i]) begin
                        rdMux = {30'h00000000, cmdValue[i]};
                        rdOk = 1'b1;
                    end
                end
            end
        endcase
    end

    always_comb begin
        case (link.parId)
            PAR_TORQ_LIM, PAR_SPEED_LIM, PAR_POS_WIN, PAR_IP, PAR_SUBNET, PAR_GATEWAY: wrOk = 1'b1;
            default: wrOk = |cmdHit && !(|cmdRefused);
        endcase
    end

    // answer one cycle after the request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= link.parReq;
            err_r <= link.parReq && (link.parWr ? !wrOk : !rdOk);
            if (rdStb) begin
                rdata_r <= rdOk ? rdMux : 32'h00000000;
            end
        end
    end

    // motion settings
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            torqLim_r <= TORQ_LIM_RST[MOT_W-1:0];
            speedLim_r <= SPEED_LIM_RST[MOT_W-1:0];
            posWin_r <= POS_WIN_RST[POS_W-1:0];
        end else if (wrStb) begin
            if (link.parId == PAR_TORQ_LIM) torqLim_r <= link.parWData[MOT_W-1:0];
            if (link.parId == PAR_SPEED_LIM) speedLim_r <= link.parWData[MOT_W-1:0];
            if (link.parId == PAR_POS_WIN) posWin_r <= link.parWData[POS_W-1:0];
        end
    end

    // network settings; the strap is caught on the first edge after release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ipLoaded_r <= 1'b0;
            ip_r <= '0;
            subnet_r <= SUBNET_RST;
            gateway_r <= GATEWAY_RST;
        end else if (!ipLoaded_r) begin
            ipLoaded_r <= 1'b1;
            ip_r <= {IP_PREFIX, macAddr[7:0]};
        end else if (wrStb) begin
            if (link.parId == PAR_IP) ip_r <= link.parWData;
            if (link.parId == PAR_SUBNET) subnet_r <= link.parWData;
            if (link.parId == PAR_GATEWAY) gateway_r <= link.parWData;
        end
    end

    assign link.parAck = ack_r;
    assign link.parErr = err_r;
    assign link.parRData = rdata_r;
    assign link.driveStatus = statusWord;
    assign errLatched = errLatched_r;
    assign ipAddr = ip_r;
endmodule : ddp_drive
`default_nettype wire

// ===== rtl/ddp_if.sv
// parameter access link between fieldbus controller and drive
// assumes both ends on the same clock
`default_nettype none
interface ddp_if;
    import ddp_pkg::*;
    logic parReq;
    logic parWr;
    logic [ID_W-1:0] parId;
    logic [DATA_W-1:0] parWData;
    logic parAck;
    logic parErr;
    logic [DATA_W-1:0] parRData;
    logic [15:0] driveStatus;
    modport drive (input parReq, input parWr, input parId, input parWData,
        output parAck, output parErr, output parRData, output driveStatus);
    modport master (output parReq, output parWr, output parId, output parWData,
        input parAck, input parErr, input parRData, input driveStatus);
endinterface : ddp_if
`default_nettype wire

// ===== rtl/ddp_master.sv
// controller end: software register port driving parameter accesses and commands
// assumes the drive answers every request with parAck
`default_nettype none
module ddp_master
    import ddp_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset, // async reset, high
    ddp_if.master link, // parameter link
    input wire logic [3:0] addr, // register offset
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata // read data, cycle after rd
);
    typedef enum {M_IDLE, M_ACC, M_SET, M_CLR} ddp_mstate_t;
    ddp_mstate_t state_r;
    logic [15:0] hostId_r, busId_r;
    logic [31:0] hostWData_r, busWData_r, result_r, rdata_r;
    logic req_r, busWr_r, err_r;
    logic [1:0] phaseStep_r;
    logic [2:0] phase_r;
    logic idle;

    assign idle = state_r == M_IDLE;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hostId_r <= '0;
            hostWData_r <= '0;
        end else if (wr) begin
            if (addr == MADDR_ID) hostId_r <= wdata[15:0];
            if (addr == MADDR_WDATA) hostWData_r <= wdata;
        end
    end

    // sequencer; orders arriving while busy are dropped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= M_IDLE;
            req_r <= 1'b0;
            busWr_r <= 1'b0;
            busId_r <= '0;
            busWData_r <= '0;
            result_r <= '0;
            err_r <= 1'b0;
            phaseStep_r <= 2'h0;
            phase_r <= PHASE_RST;
        end else begin
            req_r <= 1'b0;
            case (state_r)
                M_IDLE: begin
                    if (wr && addr == MADDR_GO) begin
                        req_r <= 1'b1;
                        busWr_r <= wdata[0];
                        busId_r <= hostId_r;
                        busWData_r <= hostWData_r;
                        state_r <= M_ACC;
                    end else if (wr && addr == MADDR_CMD) begin
                        req_r <= 1'b1;
                        busWr_r <= 1'b1;
                        busId_r <= wdata[15:0];
                        busWData_r <= 32'(CMD_EXEC);
                        state_r <= M_SET;
                    end else if (wr && addr == MADDR_PHASE && wdata[2:0] == PHASE_4 && phase_r == PHASE_RST) begin
                        req_r <= 1'b1;
                        busWr_r <= 1'b1;
                        busId_r <= CMD_IDS[CMD_PH3];
                        busWData_r <= 32'(CMD_EXEC);
                        phaseStep_r <= 2'h1;
                        state_r <= M_SET;
                    end
                end
                M_ACC: if (link.parAck) begin
                    result_r <= link.parRData;
                    err_r <= link.parErr;
                    state_r <= M_IDLE;
                end
                M_SET: if (link.parAck) begin
                    err_r <= link.parErr;
                    req_r <= 1'b1;
                    busWData_r <= 32'(CMD_IDLE);
                    state_r <= M_CLR;
                    if (link.parErr) phaseStep_r <= 2'h0;
                end
                M_CLR: if (link.parAck) begin
                    state_r <= M_IDLE;
                    if (phaseStep_r == 2'h1) begin
                        phase_r <= PHASE_3;
                        req_r <= 1'b1;
                        busId_r <= CMD_IDS[CMD_PH4];
                        busWData_r <= 32'(CMD_EXEC);
                        phaseStep_r <= 2'h2;
                        state_r <= M_SET;
                    end else if (phaseStep_r == 2'h2) begin
                        phase_r <= PHASE_4;
                        phaseStep_r <= 2'h0;
                    end
                end
                default: state_r <= M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_r <= '0;
        end else if (rd) begin
            case (addr)
                MADDR_ID: rdata_r <= {16'h0000, hostId_r};
                MADDR_WDATA: rdata_r <= hostWData_r;
                MADDR_RDATA: rdata_r <= result_r;
                MADDR_STAT: rdata_r <= {11'h000, phase_r, err_r, !idle, link.driveStatus};
                default: rdata_r <= 32'h00000000;
            endcase
        end
    end

    assign link.parReq = req_r;
    assign link.parWr = busWr_r;
    assign link.parId = busId_r;
    assign link.parWData = busWData_r;
    assign rdata = rdata_r;
endmodule : ddp_master
`default_nettype wire

// ===== rtl/ddp_pkg.sv
// constants shared by both ends of the diagnostic and procedure-command link
// assumes one clock domain; parameter ids are 16 bit, data words 32 bit
`default_nettype none
package ddp_pkg;
    localparam int ID_W = 16;
    localparam int DATA_W = 32;
    // parameter identities
    localparam logic [15:0] PAR_STATUS = 16'h0087;
    localparam logic [15:0] PAR_STD_WARN = 16'h000c;
    localparam logic [15:0] PAR_VEND_WARN = 16'h00b5;
    localparam logic [15:0] PAR_STAT_FLAG = 16'h000d;
    localparam logic [15:0] PAR_DIAG_NUM = 16'h0186;
    localparam logic [15:0] PAR_DIAG_MSG = 16'h005f;
    localparam logic [15:0] PAR_CMD_LIST = 16'h0019;
    localparam logic [15:0] PAR_TORQ_LIM = 16'h005c;
    localparam logic [15:0] PAR_SPEED_LIM = 16'h005b;
    localparam logic [15:0] PAR_POS_WIN = 16'h0039;
    localparam logic [15:0] PAR_MAC = 16'h03fb;
    localparam logic [15:0] PAR_IP = 16'h03fc;
    localparam logic [15:0] PAR_SUBNET = 16'h03fd;
    localparam logic [15:0] PAR_GATEWAY = 16'h03fe;
    // procedure commands, index order fixes the fire vector
    localparam int NCMD = 13;
    localparam logic [15:0] CMD_IDS [NCMD] = '{16'h0063, 16'h007f, 16'h0080, 16'h008b, 16'h0094, 16'h00aa,
        16'h00bf, 16'h0106, 16'h0107, 16'h0108, 16'h01a4, 16'h01a6, 16'h01bf};
    localparam int CMD_CLR_ERR = 0;
    localparam int CMD_PH3 = 1;
    localparam int CMD_PH4 = 2;
    localparam logic [NCMD-1:0] CMD_PROFILE_MASK = 13'h1ff8;
    localparam logic [1:0] CMD_EXEC = 2'h3;
    localparam logic [1:0] CMD_IDLE = 2'h0;
    // bit positions
    localparam int STAT_WARN_BIT = 12;
    localparam int STAT_ERR_BIT = 13;
    localparam int STD_UV_BIT = 9;
    localparam int STD_VEND_BIT = 15;
    localparam int VEND_POS_BIT = 0;
    localparam int VEND_NEG_BIT = 1;
    localparam int FLAG_TORQ_BIT = 4;
    localparam int FLAG_SPEED_BIT = 5;
    localparam int FLAG_INPOS_BIT = 6;
    // diagnostic numbers and four-letter texts
    localparam logic [31:0] DIAG_NONE = 32'h00000000;
    localparam logic [31:0] DIAG_UV = 32'hc00e2026;
    localparam logic [31:0] DIAG_POS = 32'hc00e8029;
    localparam logic [31:0] DIAG_NEG = 32'hc00e8030;
    localparam logic [31:0] MSG_NONE = 32'h4e4f4e45;
    localparam logic [31:0] MSG_UV = 32'h55564c54;
    localparam logic [31:0] MSG_POS = 32'h504c494d;
    localparam logic [31:0] MSG_NEG = 32'h4e4c494d;
    // reset values and phase codes
    localparam logic [23:0] IP_PREFIX = 24'hc0a800;
    localparam logic [31:0] SUBNET_RST = 32'hffffff00;
    localparam logic [31:0] GATEWAY_RST = 32'h00000000;
    localparam logic [15:0] TORQ_LIM_RST = 16'hffff;
    localparam logic [15:0] SPEED_LIM_RST = 16'hffff;
    localparam logic [31:0] POS_WIN_RST = 32'h00000064;
    localparam logic [2:0] PHASE_RST = 3'h2;
    localparam logic [2:0] PHASE_3 = 3'h3;
    localparam logic [2:0] PHASE_4 = 3'h4;
    // controller register offsets
    localparam logic [3:0] MADDR_ID = 4'h0;
    localparam logic [3:0] MADDR_WDATA = 4'h1;
    localparam logic [3:0] MADDR_GO = 4'h2;
    localparam logic [3:0] MADDR_RDATA = 4'h3;
    localparam logic [3:0] MADDR_STAT = 4'h4;
    localparam logic [3:0] MADDR_CMD = 4'h5;
    localparam logic [3:0] MADDR_PHASE = 4'h6;
endpackage : ddp_pkg
`default_nettype wire

// ===== tb/ddp_link_assertions.sv
// checker for the parameter link between controller and drive
// assumes one clock; instantiated beside the link interface
`default_nettype none
module ddp_link_assertions
    import ddp_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic reset, // async reset, high
    input wire logic parReq, // request pulse
    input wire logic parWr, // write when high
    input wire logic [ID_W-1:0] parId, // parameter identity
    input wire logic [DATA_W-1:0] parWData, // write data
    input wire logic parAck, // answer pulse
    input wire logic parErr, // request refused
    input wire logic [DATA_W-1:0] parRData, // read data
    input wire logic [15:0] driveStatus // drive status word
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence rdOf(logic [15:0] id);
        parReq && !parWr && parId == id;
    endsequence
    sequence rdDone(logic [15:0] id);
        rdOf(id) ##1 (parAck && !parErr);
    endsequence
    chk_ack_one_later: assert property (parReq |=> parAck)
        else $error("request without answer one cycle later");
    chk_ack_has_cause: assert property (parAck |-> $past(parReq))
        else $error("answer without request");
    chk_err_with_ack: assert property (parErr |-> parAck)
        else $error("refusal outside an answer");
    chk_std_reserved_zero: assert property (rdDone(PAR_STD_WARN) |-> (parRData & ~32'h00008200) == 32'h0)
        else $error("reserved standard warning bits set");
    chk_vend_reserved_zero: assert property (rdDone(PAR_VEND_WARN) |-> (parRData & ~32'h00000003) == 32'h0)
        else $error("reserved vendor warning bits set");
    chk_flag_reserved_zero: assert property (rdDone(PAR_STAT_FLAG) |-> (parRData & ~32'h00000070) == 32'h0)
        else $error("reserved status flag bits set");
    chk_vendor_word_present: assert property (rdOf(PAR_VEND_WARN) |=> parAck && !parErr)
        else $error("vendor warning word refused");
    chk_warn_sets_status: assert property (rdDone(PAR_DIAG_NUM) |->
        ((parRData != DIAG_NONE) == $past(driveStatus[STAT_WARN_BIT])))
        else $error("status warning bit disagrees with diagnostic number");
    chk_diag_code_known: assert property (rdDone(PAR_DIAG_NUM) |->
        parRData inside {DIAG_NONE, DIAG_UV, DIAG_POS, DIAG_NEG})
        else $error("unknown diagnostic number");
    chk_list_read_only: assert property (parReq && parWr && parId == PAR_CMD_LIST |=> parAck && parErr)
        else $error("write to command list not refused");
endmodule : ddp_link_assertions
`default_nettype wire

// ===== tb/drive_diag_and_procedure_cmd_bench.sv
// self-checking bench: controller and drive joined by the link
// assumes package, interface and both ends compiled first
`default_nettype none
module drive_diag_and_procedure_cmd_bench;
    import ddp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, uvIn, posIn, negIn, errorEvent, driveProfile, wr, rd, errLatched, e;
    logic [15:0] torqueIn, speedIn;
    logic [31:0] posAct, posCmd, wdata, rdata, ipAddr, d, s;
    logic [47:0] macAddr;
    logic [3:0] addr;
    logic [NCMD-1:0] cmdFire;
    int errTotal, checksDone, cyc;
    int fires [NCMD];
    int want [NCMD];
    ddp_if link ();
    ddp_drive ddp_drive_inst (.clk(clk), .reset(reset), .link(link), .undervoltageWarning(uvIn),
        .posLimitHit(posIn), .negLimitHit(negIn), .torqueActual(torqueIn), .speedActual(speedIn),
        .posActual(posAct), .posCommand(posCmd), .errorEvent(errorEvent), .driveProfile(driveProfile),
        .macAddr(macAddr), .cmdFire(cmdFire), .errLatched(errLatched), .ipAddr(ipAddr));
    // second drive without the vendor word, probed directly on its own link
    ddp_if link2 ();
    ddp_drive #(.STEPPER_VARIANT(1'b0)) ddp_drive_inst2 (.clk(clk), .reset(reset), .link(link2),
        .undervoltageWarning(1'b0), .posLimitHit(posIn), .negLimitHit(negIn), .torqueActual(torqueIn),
        .speedActual(speedIn), .posActual(posAct), .posCommand(posCmd), .errorEvent(1'b0),
        .driveProfile(1'b0), .macAddr(macAddr), .cmdFire(), .errLatched(), .ipAddr());
    ddp_master ddp_master_inst (.clk(clk), .reset(reset), .link(link), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    ddp_link_assertions ddp_link_assertions_inst (.clk(clk), .reset(reset), .parReq(link.parReq),
        .parWr(link.parWr), .parId(link.parId), .parWData(link.parWData), .parAck(link.parAck),
        .parErr(link.parErr), .parRData(link.parRData), .driveStatus(link.driveStatus));
    task automatic giveVerdict();
        $display("comparisons %0d, mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : giveVerdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // data stand from the edge after the strobe until the next read
    task automatic rreg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rreg
    task automatic waitIdle();
        s = 32'h00010000;
        for (int i = 0; i < 30 && s[16]; i++)
            rreg(MADDR_STAT, s);
        if (s[16])
            chk(s, 32'h0);
    endtask : waitIdle
    task automatic par(input logic [15:0] id, input logic w, input logic [31:0] v);
        wreg(MADDR_ID, {16'h0, id});
        wreg(MADDR_WDATA, v);
        wreg(MADDR_GO, {31'h0, w});
        waitIdle();
        rreg(MADDR_RDATA, d);
        e = s[17];
    endtask : par
    task automatic chkFires();
        for (int i = 0; i < NCMD; i++)
            chk(32'(fires[i]), 32'(want[i]));
    endtask : chkFires
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        for (int i = 0; i < NCMD; i++)
            if (cmdFire[i] === 1'b1)
                fires[i]++;
        cyc++;
        if (cyc == 20000) begin
            errTotal++;
            giveVerdict();
        end
    end
    initial begin
        {reset, uvIn, posIn, negIn, errorEvent, driveProfile, wr, rd} = 8'h80;
        {torqueIn, speedIn, addr, wdata} = '0;
        {link2.parReq, link2.parWr, link2.parId, link2.parWData} = '0;
        posCmd = 32'h00001000;
        posAct = 32'h00001000;
        macAddr = 48'h0a0b0c0d0e14; // arbitrary strap, low octet 0x14
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        chk(ipAddr, {IP_PREFIX, 8'd20});
        rreg(MADDR_STAT, s);
        chk({29'h0, s[20:18]}, {29'h0, PHASE_RST});
        for (int k = 0; k < 8; k++) begin
            uvIn <= k[0];
            posIn <= k[1];
            negIn <= k[2];
            par(PAR_STD_WARN, 1'b0, 32'h0);
            chk(d, {16'h0, k[2] | k[1], 5'h0, k[0], 9'h0});
            par(PAR_VEND_WARN, 1'b0, 32'h0);
            chk(d, {30'h0, k[2], k[1]});
            par(PAR_DIAG_NUM, 1'b0, 32'h0);
            chk(d, k[0] ? DIAG_UV : k[1] ? DIAG_POS : k[2] ? DIAG_NEG : DIAG_NONE);
            par(PAR_DIAG_MSG, 1'b0, 32'h0);
            chk(d, k[0] ? MSG_UV : k[1] ? MSG_POS : k[2] ? MSG_NEG : MSG_NONE);
            rreg(MADDR_STAT, s);
            chk({31'h0, s[STAT_WARN_BIT]}, {31'h0, k != 0});
        end
        // both limits still hit here, yet the plain variant must stay silent
        link2.parId <= PAR_VEND_WARN;
        link2.parReq <= 1'b1;
        @(posedge clk);
        link2.parReq <= 1'b0;
        @(posedge clk);
        chk({30'h0, link2.parAck, link2.parErr}, 32'h3);
        chk({16'h0, link2.driveStatus}, 32'h0);
        par(PAR_TORQ_LIM, 1'b1, 32'd100);
        par(PAR_SPEED_LIM, 1'b1, 32'd200);
        // torque and speed limits probed one below and exactly at their settings, position window at and one above
        for (int k = 0; k < 2; k++) begin
            torqueIn <= 16'(99 + k);
            speedIn <= 16'(200 - k);
            posAct <= posCmd + 32'(100 + k);
            par(PAR_STAT_FLAG, 1'b0, 32'h0);
            chk(d, {25'h0, k == 0, k == 0, k == 1, 4'h0});
        end
        par(CMD_IDS[3], 1'b1, 32'h3);
        chk({31'h0, e}, 32'h1);
        driveProfile <= 1'b1;
        par(PAR_CMD_LIST, 1'b0, 32'h0);
        chk(d, {19'h0, {NCMD{1'b1}}});
        par(PAR_CMD_LIST, 1'b1, 32'h0);
        chk({31'h0, e}, 32'h1);
        errorEvent <= 1'b1;
        @(posedge clk);
        errorEvent <= 1'b0;
        @(posedge clk);
        chk({31'h0, errLatched}, 32'h1);
        rreg(MADDR_STAT, s);
        chk({31'h0, s[STAT_ERR_BIT]}, 32'h1);
        for (int i = 0; i < NCMD; i++) begin
            wreg(MADDR_CMD, {16'h0, CMD_IDS[i]});
            waitIdle();
            want[i]++;
        end
        chk({31'h0, errLatched}, 32'h0);
        chkFires();
        par(CMD_IDS[4], 1'b1, 32'h3);
        par(CMD_IDS[4], 1'b1, 32'h3);
        want[4]++;
        chkFires();
        par(CMD_IDS[4], 1'b1, 32'h0);
        par(CMD_IDS[4], 1'b1, 32'h3);
        want[4]++;
        chkFires();
        par(PAR_MAC, 1'b0, 32'h0);
        chk(d, macAddr[31:0]);
        par(PAR_SUBNET, 1'b0, 32'h0);
        chk(d, SUBNET_RST);
        par(PAR_GATEWAY, 1'b0, 32'h0);
        chk(d, GATEWAY_RST);
        par(PAR_IP, 1'b1, {IP_PREFIX, 8'h15});
        chk(ipAddr, {IP_PREFIX, 8'h15});
        chk({31'h0, e}, 32'h0);
        wreg(MADDR_PHASE, 32'h4);
        repeat (12) @(posedge clk);
        waitIdle();
        rreg(MADDR_STAT, s);
        chk({29'h0, s[20:18]}, {29'h0, PHASE_4});
        want[CMD_PH3]++;
        want[CMD_PH4]++;
        chkFires();
        giveVerdict();
    end
endmodule : drive_diag_and_procedure_cmd_bench
`default_nettype wire
